/* File: inc/data_memory_defines.vh */
/*
 * Address map, operation codes, table read constants and field layouts
 * for the data memory and table read unit.
 * Assumes it is included by bare name from design files that need them.
 */
`ifndef DATA_MEMORY_DEFINES_VH
`define DATA_MEMORY_DEFINES_VH

// ****************************************************************
// Special purpose area, one byte per address, starting at 00H.
// ****************************************************************
`define ADDR_INDIRECT_PORT_FIRST   8'h00
`define ADDR_POINTER_FIRST         8'h01
`define ADDR_INDIRECT_PORT_SECOND  8'h02
`define ADDR_POINTER_SECOND        8'h03
`define ADDR_WORKING_REGISTER      8'h05
`define ADDR_TABLE_POINTER         8'h07
`define ADDR_TABLE_HIGH_BYTE       8'h08

// ****************************************************************
// General purpose area starts at 40H, after a gap following the special purpose area.
// ****************************************************************
`define GP_BASE                    8'h40
`define GP_DEPTH                   64
`define GP_ADDR_W                  6

// ****************************************************************
// Operation codes presented by the core.
// ****************************************************************
`define OP_READ                    3'h0
`define OP_WRITE                   3'h1
`define OP_BIT_SET                 3'h2
`define OP_BIT_CLEAR               3'h3
`define OP_TABLE_READ_CURRENT      3'h4
`define OP_TABLE_READ_LAST         3'h5

// ****************************************************************
// Program memory: 1K words of 14 bits, last page base 0300H.
// ****************************************************************
`define PMEM_ADDR_W                10
`define PMEM_DATA_W                14
`define PMEM_LAST_PAGE             2'h3
`define PMEM_LAST_PAGE_BASE        10'h300
`define TABLE_HIGH_W               6

// ****************************************************************
// Reset values.
// ****************************************************************
`define RESET_BYTE                 8'h00
`define UNUSED_READ_VALUE          8'h00

`endif

/* File: verilog/gp_byte_ram.v */
/*
 * General purpose byte RAM built from flip-flops, one write port and one
 * combinational read port, addressed by an index.
 * Assumes the caller gates the write enable to in-range addresses.
 */
`timescale 1ns/1ps
`default_nettype none

module gp_byte_ram #(
  parameter DEPTH  = 64,
  parameter ADDR_W = 6
) (
  // Clock.
  input  wire              ref_clk,
  // Write port.
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_idx,
  input  wire [7:0]        wr_data,
  // Read port.
  input  wire [ADDR_W-1:0] rd_idx,
  output wire [7:0]        rd_data
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  reg [7:0] mem_reg [0:DEPTH-1];  // Volatile contents, not reset.

  // Every location takes a write under program control.
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  // Reads are combinational so bit operations can modify in one cycle.
  assign rd_data = mem_reg[rd_idx];

endmodule

`default_nettype wire

/* File: verilog/data_memory_table_read_unit.v */
/*
 * Data memory and table read unit: special purpose registers, general
 * purpose RAM, indirect ports, bit set and clear, working register, and
 * the two-cycle table read from program memory.
 * Assumes the core issues one operation per cycle while op_ready is high
 * and that program memory answers combinationally while pmem_en is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "data_memory_defines.vh"

module data_memory_table_read_unit #(
  parameter GP_DEPTH  = `GP_DEPTH,
  parameter GP_ADDR_W = `GP_ADDR_W
) (
  // Clock and synchronous active low reset.
  input  wire                    ref_clk,
  input  wire                    rstn,
  // Operation request from the core.
  input  wire                    op_valid,
  input  wire [2:0]              op_code,
  input  wire [7:0]              op_addr,
  input  wire [7:0]              op_wdata,
  input  wire [2:0]              op_bit,
  output wire                    op_ready,
  // Read answer.
  output wire [7:0]              rd_data,
  output wire                    rd_valid,
  output wire                    table_done,
  // Program counter page for current page table reads.
  input  wire [1:0]              pc_page,
  // ALU result load into the working register.
  input  wire                    alu_load,
  input  wire [7:0]              alu_result,
  output wire [7:0]              working_register,
  output wire [7:0]              table_high_byte,
  // Program memory read port.
  output wire                    pmem_en,
  output wire [`PMEM_ADDR_W-1:0] pmem_addr,
  input  wire [`PMEM_DATA_W-1:0] pmem_data
);

  // ****************************************************************
  // State and storage.
  // ****************************************************************
  localparam TBL_IDLE = 1'b0;  // No table read in flight.
  localparam TBL_WAIT = 1'b1;  // Waiting for the program word.

  reg                     tbl_state_reg;      // Table read sequencer.
  reg                     tbl_state_next;     // Its next value.
  reg [7:0]               pointer_first_reg;  // First memory pointer.
  reg [7:0]               pointer_second_reg; // Second memory pointer.
  reg [7:0]               table_ptr_reg;      // Table pointer offset.
  reg [7:0]               work_reg;           // Working register.
  reg [`TABLE_HIGH_W-1:0] tbl_high_reg;       // Table high byte bits.
  reg [7:0]               tbl_dest_reg;       // Resolved destination.
  reg                     tbl_dest_port_reg;  // Destination is a port.
  reg [7:0]               rd_data_reg;        // Registered read data.
  reg                     rd_valid_reg;       // Read answer pulse.
  reg                     table_done_reg;     // Table read done pulse.
  reg                     pmem_en_reg;        // Program memory strobe.
  reg [`PMEM_ADDR_W-1:0]  pmem_addr_reg;      // Program memory address.

  // ****************************************************************
  // Request decode and indirect redirection.
  // ****************************************************************
  // A request is only taken while no table read is in flight.
  wire take = op_valid && (tbl_state_reg == TBL_IDLE);

  wire is_table = (op_code == `OP_TABLE_READ_CURRENT) ||
                  (op_code == `OP_TABLE_READ_LAST);

  // The ports hold no storage; their address selects a pointer instead.
  wire [7:0] eff_addr =
    (op_addr == `ADDR_INDIRECT_PORT_FIRST)  ? pointer_first_reg :
    (op_addr == `ADDR_INDIRECT_PORT_SECOND) ? pointer_second_reg :
    op_addr;

  wire via_port = (op_addr == `ADDR_INDIRECT_PORT_FIRST) ||
                  (op_addr == `ADDR_INDIRECT_PORT_SECOND);

  // A pointer that itself names a port leads nowhere.
  wire eff_is_port = via_port &&
                     ((eff_addr == `ADDR_INDIRECT_PORT_FIRST) ||
                      (eff_addr == `ADDR_INDIRECT_PORT_SECOND));

  // ****************************************************************
  // Data memory read mux.
  // ****************************************************************
  wire [7:0] gp_rd_data;  // General purpose RAM output.

  // General purpose space starts at GP_BASE, after the gap beyond the special area.
  wire in_gp_rd = (eff_addr >= `GP_BASE) &&
                  ({1'b0, eff_addr} <
                   ({1'b0, `GP_BASE} + GP_DEPTH[8:0]));
  wire [7:0] gp_rd_off = eff_addr - `GP_BASE;

  reg [7:0] cur_byte;  // Byte addressed by the current request.

  // Unused addresses, including the gap before RAM, read as zero.
  always @* begin
    cur_byte = `UNUSED_READ_VALUE;
    if (eff_is_port) begin
      cur_byte = `UNUSED_READ_VALUE;
    end else if (in_gp_rd) begin
      cur_byte = gp_rd_data;
    end else begin
      case (eff_addr)
        `ADDR_POINTER_FIRST:    cur_byte = pointer_first_reg;
        `ADDR_POINTER_SECOND:   cur_byte = pointer_second_reg;
        `ADDR_WORKING_REGISTER: cur_byte = work_reg;
        `ADDR_TABLE_POINTER:    cur_byte = table_ptr_reg;
        `ADDR_TABLE_HIGH_BYTE:  cur_byte = {2'b00, tbl_high_reg};
        default:                cur_byte = `UNUSED_READ_VALUE;
      endcase
    end
  end

  // ****************************************************************
  // Write path shared by direct writes, bit ops and table completion.
  // ****************************************************************
  wire [7:0] bit_mask = 8'h01 << op_bit;

  reg       wr_en;    // A byte is written this cycle.
  reg [7:0] wr_addr;  // Resolved byte address of the write.
  reg [7:0] wr_data;  // Byte to be written.

  // Only one source can write per cycle because table completion
  // blocks new requests; bit ops read and write in the same cycle.
  always @* begin
    wr_en   = 1'b0;
    wr_addr = eff_addr;
    wr_data = op_wdata;
    if (tbl_state_reg == TBL_WAIT) begin
      wr_en   = !tbl_dest_port_reg;
      wr_addr = tbl_dest_reg;
      wr_data = pmem_data[7:0];
    end else if (take && !eff_is_port) begin
      case (op_code)
        `OP_WRITE: begin
          wr_en = 1'b1;
        end
        `OP_BIT_SET: begin
          wr_en   = 1'b1;
          wr_data = cur_byte | bit_mask;
        end
        `OP_BIT_CLEAR: begin
          wr_en   = 1'b1;
          wr_data = cur_byte & ~bit_mask;
        end
        default: begin
          wr_en = 1'b0;
        end
      endcase
    end
  end

  wire in_gp_wr = (wr_addr >= `GP_BASE) &&
                  ({1'b0, wr_addr} <
                   ({1'b0, `GP_BASE} + GP_DEPTH[8:0]));
  wire [7:0] gp_wr_off = wr_addr - `GP_BASE;

  // ****************************************************************
  // General purpose RAM.
  // ****************************************************************
  gp_byte_ram #(
    .DEPTH  (GP_DEPTH),
    .ADDR_W (GP_ADDR_W)
  ) u_gp_ram (
    .ref_clk (ref_clk),
    .wr_en   (wr_en && in_gp_wr),
    .wr_idx  (gp_wr_off[GP_ADDR_W-1:0]),
    .wr_data (wr_data),
    .rd_idx  (gp_rd_off[GP_ADDR_W-1:0]),
    .rd_data (gp_rd_data)
  );

  // ****************************************************************
  // Table read sequencer.
  // ****************************************************************
  // Issue cycle plus capture cycle gives the two-cycle instruction.
  always @* begin
    tbl_state_next = tbl_state_reg;
    case (tbl_state_reg)
      TBL_IDLE: begin
        if (take && is_table) begin
          tbl_state_next = TBL_WAIT;
        end
      end
      TBL_WAIT: begin
        tbl_state_next = TBL_IDLE;
      end
      default: begin
        tbl_state_next = TBL_IDLE;
      end
    endcase
  end

  // Sequencer state, program memory strobe and destination capture.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      tbl_state_reg     <= TBL_IDLE;
      pmem_en_reg       <= 1'b0;
      pmem_addr_reg     <= {`PMEM_ADDR_W{1'b0}};
      tbl_dest_reg      <= `RESET_BYTE;
      tbl_dest_port_reg <= 1'b0;
      table_done_reg    <= 1'b0;
    end else begin
      tbl_state_reg  <= tbl_state_next;
      pmem_en_reg    <= 1'b0;
      table_done_reg <= (tbl_state_reg == TBL_WAIT);
      if (take && is_table) begin
        pmem_en_reg       <= 1'b1;
        tbl_dest_reg      <= eff_addr;
        tbl_dest_port_reg <= eff_is_port;
        if (op_code == `OP_TABLE_READ_LAST) begin
          // Last page base 0300H with the pointer as the offset.
          pmem_addr_reg <= `PMEM_LAST_PAGE_BASE |
                           {2'b00, table_ptr_reg};
        end else begin
          pmem_addr_reg <= {pc_page, table_ptr_reg};
        end
      end
    end
  end

  // ****************************************************************
  // Table high byte register.
  // ****************************************************************
  // Only a completed table read loads it; program writes never do,
  // so an interrupt routine's table read can overwrite it.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      tbl_high_reg <= {`TABLE_HIGH_W{1'b0}};
    end else if (tbl_state_reg == TBL_WAIT) begin
      tbl_high_reg <= pmem_data[`PMEM_DATA_W-1:8];
    end
  end

  // ****************************************************************
  // Special purpose registers.
  // ****************************************************************
  // Pointers, table pointer and working register accept writes; the
  // table high byte address only holds table_ptr_reg, so writes to it are dropped.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      pointer_first_reg  <= `RESET_BYTE;
      pointer_second_reg <= `RESET_BYTE;
      table_ptr_reg      <= `RESET_BYTE;
      work_reg           <= `RESET_BYTE;
    end else begin
      if (wr_en) begin
        case (wr_addr)
          `ADDR_POINTER_FIRST:    pointer_first_reg  <= wr_data;
          `ADDR_POINTER_SECOND:   pointer_second_reg <= wr_data;
          `ADDR_TABLE_POINTER:    table_ptr_reg      <= wr_data;
          `ADDR_WORKING_REGISTER: work_reg           <= wr_data;
          `ADDR_TABLE_HIGH_BYTE:  table_ptr_reg <= table_ptr_reg;
          default:                table_ptr_reg <= table_ptr_reg;
        endcase
      end
      // The ALU result load wins over a memory write in the same cycle.
      if (alu_load) begin
        work_reg <= alu_result;
      end
    end
  end

  // ****************************************************************
  // Read answer.
  // ****************************************************************
  // There is no move opcode; a copy reads into the core, goes through
  // the working register, and comes back as a separate write.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      rd_data_reg  <= `RESET_BYTE;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= take && (op_code == `OP_READ);
      if (take && (op_code == `OP_READ)) begin
        rd_data_reg <= cur_byte;
      end
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign op_ready         = (tbl_state_reg == TBL_IDLE);
  assign rd_data          = rd_data_reg;
  assign rd_valid         = rd_valid_reg;
  assign table_done       = table_done_reg;
  assign working_register = work_reg;
  assign table_high_byte  = {2'b00, tbl_high_reg};
  assign pmem_en          = pmem_en_reg;
  assign pmem_addr        = pmem_addr_reg;

endmodule

`default_nettype wire

/* File: bench/dmtr_assertions.sv */
/*
 * Port checker for the data memory and table read unit.
 * Assumes it is bound to the unit and sees only the unit's ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "data_memory_defines.vh"

module dmtr_assertions (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic        op_ready,
  input wire logic        rd_valid,
  input wire logic        table_done,
  input wire logic [1:0]  pc_page,
  input wire logic        alu_load,
  input wire logic [7:0]  alu_result,
  input wire logic [7:0]  working_register,
  input wire logic [7:0]  table_high_byte,
  input wire logic        pmem_en,
  input wire logic [9:0]  pmem_addr,
  input wire logic [13:0] pmem_data
);
  // ****************************************************************
  // Helpers and sequences.
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // A taken table read of either page kind.
  wire       tbl_take = op_valid && op_ready && (op_code[2:1] == 2'b10);
  wire [5:0] pw_hi    = pmem_data[13:8];
  sequence s_fetch;
    pmem_en && !op_ready;
  endsequence
  sequence s_done;
    table_done && op_ready;
  endsequence

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_table_two_cycle: assert property (tbl_take
    |=> s_fetch ##1 s_done) else $error("table read timing wrong");
  a_ready_low_cause: assert property (!op_ready |-> $past(tbl_take))
    else $error("op_ready low without table take");
  a_last_page_base: assert property (tbl_take
    && op_code == `OP_TABLE_READ_LAST |=> pmem_addr[9:8] == `PMEM_LAST_PAGE)
    else $error("last page wrong");
  a_current_page_sel: assert property (tbl_take
    && op_code == `OP_TABLE_READ_CURRENT |=> pmem_addr[9:8] == $past(pc_page))
    else $error("current page wrong");
  a_high_byte_load: assert property (pmem_en
    |=> table_high_byte[5:0] == $past(pw_hi)) else $error("high byte load");
  a_high_byte_hold: assert property (!pmem_en
    |=> $stable(table_high_byte))
    else $error("high byte changed without table read");
  a_high_bits_zero: assert property (table_high_byte[7:6] == 2'b00)
    else $error("unused high bits set");
  a_alu_load_wreg: assert property (alu_load
    |=> working_register == $past(alu_result)) else $error("alu load lost");
  a_read_answer: assert property (op_valid && op_ready
    && op_code == `OP_READ |=> rd_valid) else $error("read not answered");
endmodule

bind data_memory_table_read_unit dmtr_assertions u_dmtr_assertions (
  .ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
  .op_ready(op_ready), .rd_valid(rd_valid), .table_done(table_done),
  .pc_page(pc_page), .alu_load(alu_load), .alu_result(alu_result),
  .working_register(working_register), .table_high_byte(table_high_byte),
  .pmem_en(pmem_en), .pmem_addr(pmem_addr), .pmem_data(pmem_data));
`default_nettype wire

/* File: bench/pmem_model.sv */
/*
 * Program memory model: 1K words of 14 bits, answering in the fetch cycle.
 * Assumes the unit samples the word in the cycle pmem_en is high.
 */
`timescale 1ns/1ps
`default_nettype none

module pmem_model (
  input  wire logic        ref_clk,
  input  wire logic        pmem_en,
  input  wire logic [9:0]  pmem_addr,
  output wire logic [13:0] pmem_data
);
  // Outside a fetch the word toggles, so a stale capture shows up.
  logic [13:0] junk_reg = 14'h2AAA;
  always @(posedge ref_clk) begin
    junk_reg <= ~junk_reg;
  end
  // Word content is a fixed scramble of its 10-bit address.
  assign pmem_data = pmem_en ?
                     ({pmem_addr[3:0], pmem_addr} ^ 14'h2C35) :
                     junk_reg;
endmodule
`default_nettype wire

/* File: bench/data_memory_table_read_unit_tb_top.sv */
/*
 * Self-checking bench for the data memory and table read unit.
 * Assumes the checker is bound and pmem_model stands for program memory.
 */
`timescale 1ns/1ps
`default_nettype none

module data_memory_table_read_unit_tb_top;
  logic        ref_clk    = 1'b0;
  logic        rstn       = 1'b0;
  logic        op_valid   = 1'b0;
  logic        alu_load   = 1'b0;
  logic [2:0]  op_code    = 3'h0;
  logic [2:0]  op_bit     = 3'h0;
  logic [7:0]  op_addr    = 8'h00;
  logic [7:0]  op_wdata   = 8'h00;
  logic [7:0]  alu_result = 8'h00;
  logic [1:0]  pc_page    = 2'h0;
  wire         op_ready, rd_valid, table_done, pmem_en;
  wire  [7:0]  rd_data, working_register, table_high_byte;
  wire  [9:0]  pmem_addr;
  wire  [13:0] pmem_data;
  integer      seed = 32'hDCD861D9;
  integer      fail_count = 0;
  integer      checks_done = 0;
  integer      cyc = 0;
  integer      i, r;
  logic [7:0]  mm [0:255]; // Expected data memory contents.

  data_memory_table_read_unit u_data_memory_table_read_unit (
    .ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_wdata(op_wdata), .op_bit(op_bit),
    .op_ready(op_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .table_done(table_done), .pc_page(pc_page), .alu_load(alu_load),
    .alu_result(alu_result), .working_register(working_register),
    .table_high_byte(table_high_byte), .pmem_en(pmem_en),
    .pmem_addr(pmem_addr), .pmem_data(pmem_data));
  pmem_model u_pmem_model (.ref_clk(ref_clk), .pmem_en(pmem_en),
    .pmem_addr(pmem_addr), .pmem_data(pmem_data));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // A hang is cut short well beyond the roughly 600 cycles needed.
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      fail_count = fail_count + 1;
      results;
    end
  end

  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  // Indirect ports redirect one level through their pointer.
  function [7:0] tgt(input [7:0] ad);
    tgt = (ad == 8'h00) ? mm[1] : (ad == 8'h02) ? mm[3] : ad;
  endfunction
  function ok_w(input [7:0] t);
    ok_w = t == 1 || t == 3 || t == 5 || t == 7 || t[7:6] == 2'b01;
  endfunction
  function [7:0] exp_rd(input [7:0] ad);
    reg [7:0] t;
    begin
      t = tgt(ad);
      exp_rd = (ok_w(t) || t == 8'h08) ? mm[t] : 8'h00;
    end
  endfunction

  // One request, held for one clock edge; leaves op_valid high for the caller.
  task op(input [2:0] c, input [7:0] ad, input [7:0] d, input [2:0] b);
    reg [7:0] t;
    begin
      t = tgt(ad);
      op_valid = 1'b1;
      op_code = c;
      op_addr = ad;
      op_wdata = d;
      op_bit = b;
      @(posedge ref_clk);
      #1;
      if (c == 3'h0) begin
        chk(rd_valid, 1);
        chk(rd_data, exp_rd(ad));
      end else if (c == 3'h1 && ok_w(t)) begin
        mm[t] = d;
      end else if ((c == 3'h2 || c == 3'h3) && ok_w(t)) begin
        mm[t][b] = (c == 3'h2);
      end
    end
  endtask

  // Table read with a refused write attempted in the fetch cycle.
  task tbl(input [2:0] c, input [7:0] p, input [7:0] dst);
    reg [13:0] w;
    reg [9:0]  ea;
    begin
      op(3'h1, 8'h07, p, 3'h0);
      r = $random(seed);
      pc_page = r[1:0];
      ea = (c == 3'h4) ? {r[1:0], p} : {2'b11, p};
      w = {ea[3:0], ea} ^ 14'h2C35;
      op_code = c;
      op_addr = dst;
      @(posedge ref_clk);
      #1;
      chk(pmem_en, 1);
      chk(op_ready, 0);
      chk(pmem_addr, ea);
      op_code = 3'h1;
      op_wdata = 8'hEE;
      @(posedge ref_clk);
      #1;
      chk(table_done, 1);
      chk(table_high_byte, {2'b00, w[13:8]});
      mm[dst] = w[7:0];
      mm[8] = {2'b00, w[13:8]};
      op(3'h0, dst, 8'h00, 3'h0);
    end
  endtask

  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      mm[i] = 8'h00;
    end
    repeat (5) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    chk(op_ready, 1);
    chk(working_register, 0);
    chk(table_high_byte, 0);
    // Fill general purpose area, then read across both area edges.
    for (i = 8'h40; i < 8'h80; i = i + 1) begin
      r = $random(seed);
      op(3'h1, i[7:0], r[7:0], 3'h0);
    end
    for (i = 8'h3C; i < 8'h84; i = i + 1) begin
      op(3'h0, i[7:0], 8'h00, 3'h0);
    end
    $display("test general area done");
    // Special area writes incl. protected, unused and indirect ports.
    for (i = 0; i < 32; i = i + 1) begin
      r = $random(seed);
      op(3'h1, {4'h0, i[3:0]}, r[7:0], 3'h0);
      op(3'h0, {4'h0, r[11:8]}, 8'h00, 3'h0);
    end
    op(3'h1, 8'h01, 8'h02, 3'h0);
    op(3'h1, 8'h00, 8'h77, 3'h0);
    op(3'h0, 8'h00, 8'h00, 3'h0);
    $display("test special area done");
    // Bit set and clear on every position, and bit set on the read-only byte.
    for (i = 0; i < 8; i = i + 1) begin
      op(3'h2, 8'h40, 8'h00, i[2:0]);
      op(3'h3, 8'h41, 8'h00, i[2:0]);
      op(3'h2, 8'h08, 8'h00, i[2:0]);
      op(3'h0, 8'h40, 8'h00, 3'h0);
      op(3'h0, 8'h41, 8'h00, 3'h0);
    end
    // ALU load wins over a same-cycle memory write to the working byte.
    r = $random(seed);
    alu_result = r[7:0];
    alu_load = 1'b1;
    op(3'h1, 8'h05, 8'h11, 3'h0);
    alu_load = 1'b0;
    mm[5] = alu_result;
    op(3'h0, 8'h05, 8'h00, 3'h0);
    // Table reads of both kinds, pointers 06H and FFH first.
    tbl(3'h5, 8'h06, 8'h41);
    tbl(3'h4, 8'hFF, 8'h7F);
    for (i = 0; i < 12; i = i + 1) begin
      r = $random(seed);
      tbl(r[8] ? 3'h4 : 3'h5, r[7:0], {2'b01, r[14:9]});
    end
    op(3'h1, 8'h08, 8'h5A, 3'h0);
    op(3'h0, 8'h08, 8'h00, 3'h0);
    $display("test table read done");
    // Random mix of plain operations, unused codes included.
    for (i = 0; i < 300; i = i + 1) begin
      r = $random(seed);
      op((r[2:1] == 2'b10) ? 3'h0 : r[2:0],
         r[6] ? {2'b01, r[13:8]} : {4'h0, r[11:8]}, r[23:16], r[26:24]);
    end
    op_valid = 1'b0;
    $display("test random mix done");
    results;
  end
endmodule
`default_nettype wire
